// file: verilog/vst_pkg.sv
// vst_pkg: constants, types and register map of the transfer sequencer.
// assumes a 32-bit AXI4-Lite register bus with byte addresses.
package vst_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_F0START  = 8'h04;
    localparam logic [7:0] REG_F1START  = 8'h08;
    localparam logic [7:0] REG_LINE_INCREMENT  = 8'h0C;
    localparam logic [7:0] REG_SPLITINC = 8'h10;
    localparam logic [7:0] REG_SPLITMSK = 8'h14;
    localparam logic [7:0] REG_COLMSK   = 8'h18;
    localparam logic [7:0] REG_CURRENT  = 8'h1C;
    localparam logic [7:0] REG_NEXT     = 8'h20;
    localparam logic [7:0] REG_STATUS   = 8'h24;

    // ------------------------------------------------------------
    // frame_memory_control fields
    // ------------------------------------------------------------
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_OVF_EN   = 2;
    localparam int CTL_INTERLACE = 3;
    localparam int CTL_LINE_RPT = 4;
    localparam int CTL_HALF_BUF = 5;
    localparam logic [31:0] CTL_WMASK   = 32'h0000_003F;
    localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
    localparam logic [31:0] RST_SPLITINC = 32'h0000_0400;
    localparam logic [31:0] RST_SPLITMSK = 32'h0000_03F8;
    localparam logic [31:0] RST_COLMSK   = 32'h0000_0FF8;

    // status fields
    localparam int STS_BUSY     = 0;
    localparam int STS_PEND_SOF = 1;
    localparam int STS_PEND_LN  = 2;
    localparam int STS_PEND_OVF = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        MODE_DISPLAY,
        MODE_CAPTURE,
        MODE_MERGE,
        MODE_RESERVED
    } vst_mode_e;

    typedef enum logic [1:0] {
        EV_SOF,
        EV_LINE,
        EV_OVF
    } vst_event_e;

    // one transfer request to the transfer controller
    typedef struct packed {
        logic        full;
        logic        write;
        logic [31:0] addr;
    } vst_xfer_s;

endpackage : vst_pkg

// file: verilog/vst_sequencer.sv
// vst_sequencer: address generator and transfer sequencer for one frame memory.
// assumes frame timers deliver one-cycle start-of-field and line pulses and
// the serial clock arrives as a one-cycle enable; all inputs synchronous.
//
// How it works
// - two-bit mode field picks display, capture or merge capture
// - address updates depend on event and interlace settings, not on mode
// - field start: transfers at start address, copy to current, next=field1+step
// - line: on the cycle the transfer list is latched, current takes next, next advances by step
// - current address increments on each serial clock pulse, except one in a field or line start cycle
// - next advances by line increment, doubled when interlaced without line repeat
// - display field/line: full read at next address
// - display, overflow on and upper half: split read at masked next plus inc
// - display overflow: split read at masked current plus inc
// - capture field start: full write, row from current, column from next
// - capture, overflow on: then split write at masked next plus inc
// - capture line repeats the field start sequence
// - capture overflow: split write at masked current minus inc
// - half buffers: overflow split write address xored with twice inc
// - merge field start: full read then full write at next address
// - merge start, upper half: split write minus inc, split read plus inc
// - merge start, lower half: split write at masked current plus inc
// - merge line, upper half: first split read at masked current minus inc
// - merge line: full write row/column, then the merge start sequence
// - merge overflow: split write minus inc, then split read plus inc
// - overflow event when current wraps past the split mask bits
// - interlaced line repeat advances next by a single increment
`timescale 1ns/10ps
module vst_sequencer #(
    parameter int SEQ_DEPTH = 6
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              sof_req,
    input  wire logic              field_sel,
    input  wire logic              line_req,
    input  wire logic              sclk_pulse,
    output logic                   xfer_valid,
    input  wire logic              xfer_ready,
    output vst_pkg::vst_xfer_s     xfer
);

    initial begin
        if (SEQ_DEPTH < 6 || SEQ_DEPTH > 7) begin
            $error("SEQ_DEPTH must be 6 or 7");
        end
    end

    typedef enum logic {ST_IDLE, ST_ISSUE} vst_state_e;

    function automatic logic [31:0] vst_wmerge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) r[8*b +: 8] = wd[8*b +: 8];
        end
        return r;
    endfunction : vst_wmerge

    function automatic vst_pkg::vst_xfer_s vst_mk(input logic full, input logic wr,
                                                  input logic [31:0] a);
        vst_pkg::vst_xfer_s x;
        x.full  = full;
        x.write = wr;
        x.addr  = a;
        return x;
    endfunction : vst_mk

    // ------------------------------------------------------------
    // registers and bus slave
    // ------------------------------------------------------------
    logic [31:0] ctrl_q, f0_q, f1_q, linc_q, sinc_q, smask_q, cmask_q;
    logic [31:0] cur_q, next_q;
    logic        pend_sof_q, pend_ln_q, pend_ovf_q, fsel_q;
    vst_state_e  state_q;
    logic        wr_go, rd_go;
    logic [31:0] rd_val;
    logic        rd_hit, wr_hit;

    // both write channels are taken together; one write in flight at a time
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = rd_go;

    always_comb begin
        wr_hit = 1'b1;
        unique case (s_axi_awaddr)
            vst_pkg::REG_CTRL, vst_pkg::REG_F0START, vst_pkg::REG_F1START,
            vst_pkg::REG_LINE_INCREMENT, vst_pkg::REG_SPLITINC, vst_pkg::REG_SPLITMSK,
            vst_pkg::REG_COLMSK, vst_pkg::REG_CURRENT, vst_pkg::REG_NEXT,
            vst_pkg::REG_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_val = vst_pkg::RST_ZERO;
        unique case (s_axi_araddr)
            vst_pkg::REG_CTRL:     rd_val = ctrl_q;
            vst_pkg::REG_F0START:  rd_val = f0_q;
            vst_pkg::REG_F1START:  rd_val = f1_q;
            vst_pkg::REG_LINE_INCREMENT:  rd_val = linc_q;
            vst_pkg::REG_SPLITINC: rd_val = sinc_q;
            vst_pkg::REG_SPLITMSK: rd_val = smask_q;
            vst_pkg::REG_COLMSK:   rd_val = cmask_q;
            vst_pkg::REG_CURRENT:  rd_val = cur_q;
            vst_pkg::REG_NEXT:     rd_val = next_q;
            vst_pkg::REG_STATUS: begin
                rd_val[vst_pkg::STS_BUSY]     = (state_q == ST_ISSUE);
                rd_val[vst_pkg::STS_PEND_SOF] = pend_sof_q;
                rd_val[vst_pkg::STS_PEND_LN]  = pend_ln_q;
                rd_val[vst_pkg::STS_PEND_OVF] = pend_ovf_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_q  <= vst_pkg::RST_ZERO;
            f0_q    <= vst_pkg::RST_ZERO;
            f1_q    <= vst_pkg::RST_ZERO;
            linc_q  <= vst_pkg::RST_ZERO;
            sinc_q  <= vst_pkg::RST_SPLITINC;
            smask_q <= vst_pkg::RST_SPLITMSK;
            cmask_q <= vst_pkg::RST_COLMSK;
        end else if (wr_go) begin
            unique case (s_axi_awaddr)
                vst_pkg::REG_CTRL: ctrl_q <= vst_wmerge(ctrl_q, s_axi_wdata, s_axi_wstrb)
                                           & vst_pkg::CTL_WMASK;
                vst_pkg::REG_F0START:  f0_q    <= vst_wmerge(f0_q, s_axi_wdata, s_axi_wstrb);
                vst_pkg::REG_F1START:  f1_q    <= vst_wmerge(f1_q, s_axi_wdata, s_axi_wstrb);
                vst_pkg::REG_LINE_INCREMENT:  linc_q  <= vst_wmerge(linc_q, s_axi_wdata, s_axi_wstrb);
                vst_pkg::REG_SPLITINC: sinc_q  <= vst_wmerge(sinc_q, s_axi_wdata, s_axi_wstrb);
                vst_pkg::REG_SPLITMSK: smask_q <= vst_wmerge(smask_q, s_axi_wdata, s_axi_wstrb);
                vst_pkg::REG_COLMSK:   cmask_q <= vst_wmerge(cmask_q, s_axi_wdata, s_axi_wstrb);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= vst_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? vst_pkg::RESP_OKAY : vst_pkg::RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= vst_pkg::RST_ZERO;
            s_axi_rresp  <= vst_pkg::RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? vst_pkg::RESP_OKAY : vst_pkg::RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // event scheduling
    // ------------------------------------------------------------
    vst_pkg::vst_mode_e  mode;
    vst_pkg::vst_event_e ev;
    logic        ovf_en, half_buf, start, wrap;
    logic [31:0] step, sclk_step, base;

    assign mode     = vst_pkg::vst_mode_e'(ctrl_q[vst_pkg::CTL_MODE_LSB +: 2]);
    assign ovf_en   = ctrl_q[vst_pkg::CTL_OVF_EN];
    assign half_buf = ctrl_q[vst_pkg::CTL_HALF_BUF];
    // line repeat only matters when interlaced
    assign step = (ctrl_q[vst_pkg::CTL_INTERLACE] && !ctrl_q[vst_pkg::CTL_LINE_RPT])
                  ? (linc_q << 1) : linc_q;
    assign sclk_step = smask_q & (~smask_q + 32'h0000_0001);
    assign wrap  = sclk_pulse && (smask_q != vst_pkg::RST_ZERO)
                   && ((cur_q & smask_q) == smask_q);
    assign start = (state_q == ST_IDLE) && (pend_sof_q || pend_ln_q || pend_ovf_q);
    // overflow first: in capture modes it must precede the line that follows it
    assign ev = pend_ovf_q ? vst_pkg::EV_OVF : (pend_ln_q ? vst_pkg::EV_LINE : vst_pkg::EV_SOF);
    assign base = fsel_q ? f1_q : f0_q;

    // a new event landing on the clear cycle is kept
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pend_sof_q <= 1'b0;
            pend_ln_q  <= 1'b0;
            pend_ovf_q <= 1'b0;
            fsel_q     <= 1'b0;
        end else begin
            pend_sof_q <= sof_req || (pend_sof_q && !(start && ev == vst_pkg::EV_SOF));
            pend_ln_q  <= line_req || (pend_ln_q && !(start && ev == vst_pkg::EV_LINE));
            pend_ovf_q <= wrap || (pend_ovf_q && !(start && ev == vst_pkg::EV_OVF));
            if (sof_req) fsel_q <= field_sel;
        end
    end

    // ------------------------------------------------------------
    // transfer list built from the chosen event
    // ------------------------------------------------------------
    vst_pkg::vst_xfer_s lst [SEQ_DEPTH];
    logic [2:0]  cnt;
    logic [31:0] c_op, n_op, mc, mn, rowcol, flip;

    always_comb begin
        c_op   = (ev == vst_pkg::EV_SOF) ? base : cur_q;
        n_op   = (ev == vst_pkg::EV_SOF) ? base : next_q;
        mc     = c_op & ~smask_q;
        mn     = n_op & ~smask_q;
        rowcol = (c_op & ~cmask_q) | (n_op & cmask_q);
        flip   = half_buf ? (sinc_q << 1) : vst_pkg::RST_ZERO;
        cnt    = 3'd0;
        for (int i = 0; i < SEQ_DEPTH; i++) lst[i] = '0;
        unique case (mode)
            vst_pkg::MODE_DISPLAY: begin
                if (ev == vst_pkg::EV_OVF) begin
                    lst[cnt] = vst_mk(1'b0, 1'b0, mc + sinc_q); cnt = cnt + 3'd1;
                end else begin
                    lst[cnt] = vst_mk(1'b1, 1'b0, n_op); cnt = cnt + 3'd1;
                    if (ovf_en && |(n_op & sinc_q)) begin
                        lst[cnt] = vst_mk(1'b0, 1'b0, mn + sinc_q); cnt = cnt + 3'd1;
                    end
                end
            end
            vst_pkg::MODE_CAPTURE: begin
                if (ev == vst_pkg::EV_OVF) begin
                    lst[cnt] = vst_mk(1'b0, 1'b1, (mc - sinc_q) ^ flip);
                    cnt = cnt + 3'd1;
                end else begin
                    lst[cnt] = vst_mk(1'b1, 1'b1, rowcol); cnt = cnt + 3'd1;
                    if (ovf_en) begin
                        lst[cnt] = vst_mk(1'b0, 1'b1, mn + sinc_q); cnt = cnt + 3'd1;
                    end
                end
            end
            vst_pkg::MODE_MERGE: begin
                if (ev == vst_pkg::EV_OVF) begin
                    lst[cnt] = vst_mk(1'b0, 1'b1, (mc - sinc_q) ^ flip);
                    cnt = cnt + 3'd1;
                    lst[cnt] = vst_mk(1'b0, 1'b0, mc + sinc_q); cnt = cnt + 3'd1;
                end else begin
                    if (ev == vst_pkg::EV_LINE) begin
                        if (ovf_en && |(c_op & sinc_q)) begin
                            lst[cnt] = vst_mk(1'b0, 1'b0, mc - sinc_q); cnt = cnt + 3'd1;
                        end
                        lst[cnt] = vst_mk(1'b1, 1'b1, rowcol); cnt = cnt + 3'd1;
                    end
                    lst[cnt] = vst_mk(1'b1, 1'b0, n_op); cnt = cnt + 3'd1;
                    lst[cnt] = vst_mk(1'b1, 1'b1, n_op); cnt = cnt + 3'd1;
                    if (ovf_en && |(n_op & sinc_q)) begin
                        lst[cnt] = vst_mk(1'b0, 1'b1, mc - sinc_q); cnt = cnt + 3'd1;
                        lst[cnt] = vst_mk(1'b0, 1'b0, mc + sinc_q); cnt = cnt + 3'd1;
                    end else if (ovf_en) begin
                        lst[cnt] = vst_mk(1'b0, 1'b1, mc + sinc_q); cnt = cnt + 3'd1;
                    end
                end
            end
            vst_pkg::MODE_RESERVED: ; // reserved code issues nothing
        endcase
    end

    // ------------------------------------------------------------
    // address registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cur_q  <= vst_pkg::RST_ZERO;
            next_q <= vst_pkg::RST_ZERO;
        end else if (start && ev == vst_pkg::EV_SOF) begin
            cur_q  <= base;
            next_q <= f1_q + step;
        end else if (start && ev == vst_pkg::EV_LINE) begin
            cur_q  <= next_q;
            next_q <= next_q + step;
        end else if (sclk_pulse) begin
            cur_q  <= cur_q + sclk_step;
        end
    end

    // ------------------------------------------------------------
    // issue sequencer
    // ------------------------------------------------------------
    vst_pkg::vst_xfer_s seq_q [SEQ_DEPTH];
    logic [2:0] idx_q, cnt_q;

    assign xfer_valid = (state_q == ST_ISSUE);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            idx_q   <= 3'd0;
            cnt_q   <= 3'd0;
            xfer    <= '0;
            for (int i = 0; i < SEQ_DEPTH; i++) seq_q[i] <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: if (start && cnt != 3'd0) begin
                    seq_q   <= lst;
                    xfer    <= lst[0];
                    cnt_q   <= cnt;
                    idx_q   <= 3'd1;
                    state_q <= ST_ISSUE;
                end
                ST_ISSUE: if (xfer_ready) begin
                    if (idx_q == cnt_q) begin
                        state_q <= ST_IDLE;
                    end else begin
                        xfer  <= seq_q[idx_q];
                        idx_q <= idx_q + 3'd1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_sof_cur_load: assert property (
        start && ev == vst_pkg::EV_SOF |=> cur_q == $past(base))
        else $error("current not loaded from field start");
    a_sof_next_load: assert property (
        start && ev == vst_pkg::EV_SOF |=> next_q == $past(f1_q) + $past(step))
        else $error("next not field one start plus step");
    a_line_cur_move: assert property (
        start && ev == vst_pkg::EV_LINE |=> cur_q == $past(next_q))
        else $error("current not taken from next on line");
    a_line_repeat_step: assert property (
        start && ev == vst_pkg::EV_LINE && ctrl_q[vst_pkg::CTL_LINE_RPT]
        |=> next_q == $past(next_q) + $past(linc_q))
        else $error("line repeat did not add single increment");
    a_sclk_cur_inc: assert property (
        sclk_pulse && !start |=> cur_q == $past(cur_q) + $past(sclk_step))
        else $error("current missed a serial clock step");
    a_wrap_ovf_pend: assert property (
        wrap |=> pend_ovf_q)
        else $error("overflow event lost");
    a_xfer_hold_stable: assert property (
        xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer))
        else $error("transfer dropped before acceptance");
    a_display_first_read: assert property (
        state_q == ST_IDLE && start && mode == vst_pkg::MODE_DISPLAY && ev != vst_pkg::EV_OVF
        |=> xfer_valid && xfer.full && !xfer.write)
        else $error("display sequence not led by full read");
    a_resp_bhold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn");

endmodule : vst_sequencer

// file: bench/vst_xfer_model.sv
// vst_xfer_model: transfer controller stand-in, logs accepted transfers in order.
// assumes xfer stays steady while xfer_valid waits; slow stalls each transfer.
`timescale 1ns/10ps
module vst_xfer_model (
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    input  wire logic               slow,
    input  wire logic               xfer_valid,
    input  wire vst_pkg::vst_xfer_s xfer,
    output logic                    xfer_ready
);
    vst_pkg::vst_xfer_s log_q[$];
    logic [1:0]         wait_q;
    // the wait count is not cleared per transfer, so stalls vary in length
    always @(posedge clk_sys) begin
        if (!nrst) begin
            xfer_ready <= 1'h0;
            wait_q     <= 2'h0;
        end else if (xfer_valid && xfer_ready) begin
            log_q.push_back(xfer);
            xfer_ready <= 1'h0;
        end else if (xfer_valid) begin
            wait_q     <= wait_q + 2'h1;
            xfer_ready <= !slow || wait_q == 2'h3;
        end
    end
endmodule : vst_xfer_model

// file: bench/vst_sequencer_tb.sv
// vst_sequencer_tb: register and transfer sequence tests of vst_sequencer.
// assumes vst_xfer_model answers the transfer port and logs what it accepts.
`timescale 1ns/10ps
module vst_sequencer_tb;
    localparam logic [31:0] F0 = 32'h0000_2000, F1 = 32'h0000_1000, M = 32'h0000_3020;
    localparam logic [31:0] LI = 32'h0000_0100, SI = 32'h0000_0020;
    localparam logic [33:0] NO = 34'h0_0000_0000;
    logic        clk_sys = 1'h0, nrst = 1'h0, awvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0, sof_req = 1'h0, field_sel = 1'h0;
    logic        line_req = 1'h0, sclk_pulse = 1'h0, slow = 1'h0;
    logic        awready, bvalid, arready, rvalid, xfer_valid, xfer_ready;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [1:0]  rresp, bresp;
    logic        wready;
    vst_pkg::vst_xfer_s xfer;
    int          failures = 0, samples_checked = 0;
    // address and data are offered together, so one valid serves both
    vst_sequencer DUT (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(awvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sof_req(sof_req), .field_sel(field_sel), .line_req(line_req),
        .sclk_pulse(sclk_pulse), .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer(xfer));
    vst_xfer_model XC (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .xfer_valid(xfer_valid),
        .xfer(xfer), .xfer_ready(xfer_ready));
    always #25 clk_sys = ~clk_sys;
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = vst_pkg::RESP_OKAY);
        @(posedge clk_sys);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        bready  <= 1'h1;
        #1 while (awready !== 1'h1) @(posedge clk_sys) #1;
        // data channel must be taken on the same edge as the address
        chk(34'(wready), 34'h0_0000_0001);
        @(posedge clk_sys);
        awvalid <= 1'h0;
        #1 while (bvalid !== 1'h1) @(posedge clk_sys) #1;
        chk(34'(bresp), 34'(r));
        @(posedge clk_sys);
        bready  <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r = vst_pkg::RESP_OKAY);
        @(posedge clk_sys);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        #1 while (arready !== 1'h1) @(posedge clk_sys) #1;
        @(posedge clk_sys);
        arvalid <= 1'h0;
        #1 while (rvalid !== 1'h1) @(posedge clk_sys) #1;
        chk({rdata, rresp}, {e, r});
        @(posedge clk_sys);
        rready  <= 1'h0;
    endtask : rd
    // e = {field select, field start, line, slow partner}; k serial clocks
    task automatic step(input logic [7:0] c, input logic [3:0] e, input int k, input int n,
                        input logic [33:0] x0, x1 = NO, x2 = NO, x3 = NO);
        logic [33:0] x[4];
        x = '{x0, x1, x2, x3};
        wr(vst_pkg::REG_CTRL, {24'h00_0000, c});
        field_sel  <= e[3];
        sof_req    <= e[2];
        line_req   <= e[1];
        slow       <= e[0];
        sclk_pulse <= k != 0;
        repeat (k > 0 ? k : 1) @(posedge clk_sys);
        sof_req    <= 1'h0;
        line_req   <= 1'h0;
        sclk_pulse <= 1'h0;
        while (XC.log_q.size() < n) @(posedge clk_sys);
        // margin lets a surplus transfer show up in the count
        repeat (8) @(posedge clk_sys);
        chk(34'(XC.log_q.size()), 34'(n));
        for (int i = 0; i < n; i++) chk(XC.log_q[i], x[i]);
        XC.log_q.delete();
        $display("test done: mode %h, %0d transfers", c, n);
    endtask : step
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    initial begin
        #1_000_000;
        failures++;
        stop_test();
    end
    // xfer encoding: {full, write} 2 full read, 3 full write, 1 split write, 0 split read
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'h1;
        rd(vst_pkg::REG_CTRL, 32'h0000_0000);
        rd(vst_pkg::REG_SPLITMSK, vst_pkg::RST_SPLITMSK);
        rd(8'h3C, 32'h0000_0000, vst_pkg::RESP_DECERR);
        wr(8'h3C, 32'h0000_0001, vst_pkg::RESP_DECERR);
        wr(vst_pkg::REG_F0START, F0);
        wr(vst_pkg::REG_F1START, F1);
        wr(vst_pkg::REG_LINE_INCREMENT, LI);
        wr(vst_pkg::REG_SPLITINC, SI);
        wr(vst_pkg::REG_SPLITMSK, 32'h0000_0018);
        step(8'h00, 4'hC, 0, 1, {2'h2, F1});
        rd(vst_pkg::REG_NEXT, F1 + LI);
        step(8'h00, 4'h2, 0, 1, {2'h2, F1 + LI});
        rd(vst_pkg::REG_NEXT, F1 + 2 * LI);
        step(8'h04, 4'h0, 4, 1, {2'h0, F1 + LI + 2 * SI});
        rd(vst_pkg::REG_CURRENT, F1 + LI + SI);
        step(8'h08, 4'h2, 0, 1, {2'h2, F1 + 2 * LI});
        rd(vst_pkg::REG_NEXT, F1 + 4 * LI);
        step(8'h18, 4'h2, 0, 1, {2'h2, F1 + 4 * LI});
        rd(vst_pkg::REG_NEXT, F1 + 5 * LI);
        step(8'h05, 4'h4, 0, 2, {2'h3, F0}, {2'h1, F0 + SI});
        step(8'h05, 4'h0, 4, 1, {2'h1, F0});
        step(8'h25, 4'h0, 4, 1, {2'h1, F0 + 3 * SI});
        step(8'h25, 4'h2, 0, 2, {2'h3, F0 + LI}, {2'h1, F1 + LI + SI});
        wr(vst_pkg::REG_F0START, M);
        step(8'h04, 4'h4, 0, 2, {2'h2, M}, {2'h0, M + SI});
        step(8'h06, 4'h5, 0, 4, {2'h2, M}, {2'h3, M}, {2'h1, M - SI}, {2'h0, M + SI});
        step(8'h26, 4'h0, 4, 2, {2'h1, M + 2 * SI}, {2'h0, M + 2 * SI});
        // current 0x3040 (lower half), next F1+LI: row from current, column from next
        step(8'h06, 4'h2, 0, 4, {2'h3, 32'h0000_3100}, {2'h2, F1 + LI}, {2'h3, F1 + LI},
             {2'h1, M + 2 * SI});
        stop_test();
    end
endmodule : vst_sequencer_tb
